// ---- rmcfg_map.svh ----
// Offsets, field positions, reset values and rate constants
`ifndef RMCFG_MAP_SVH
`define RMCFG_MAP_SVH

// Bus geometry
`define RMCFG_ADDR_W        8
`define RMCFG_IDX_W         6
`define RMCFG_NREG          4

// Register indices; byte address is four times the index
`define RMCFG_IDX_DMOD      6'h01
`define RMCFG_IDX_FDEV      6'h02
`define RMCFG_IDX_BRATE     6'h03
`define RMCFG_IDX_FLOOR     6'h04

// Reset values
`define RMCFG_RST_DMOD      8'h88
`define RMCFG_RST_FDEV      8'h03
`define RMCFG_RST_BRATE     8'h07
`define RMCFG_RST_FLOOR     8'h0c

// Writable bits per register
`define RMCFG_MASK_FULL     8'hff
`define RMCFG_MASK_BRATE    8'h7f

// Data and modulation register fields
`define RMCFG_DMOD_MODULATION_SELECT_HI 7
`define RMCFG_DMOD_MODULATION_SELECT_LO 6
`define RMCFG_DMOD_MODE_LOW  5
`define RMCFG_DMOD_OOKT_HI   4
`define RMCFG_DMOD_OOKT_LO   3
`define RMCFG_DMOD_MODE_HIGH 2
`define RMCFG_DMOD_IFG_HI    1
`define RMCFG_DMOD_IFG_LO    0

// Rate derivation
`define RMCFG_XTAL_HZ       12800000
`define RMCFG_DEV_SHIFT     5
`define RMCFG_BR_SHIFT      6

// Bus responses
`define RMCFG_RESP_OKAY     2'h0
`define RMCFG_RESP_SLVERR   2'h2

`endif

// ---- rmcfg_pkg.sv ----
// Types shared by the modulation configuration block
package rmcfg_pkg;

	typedef enum logic [1:0] {
		mode_continuous,
		mode_buffer,
		mode_packet
	} rmcfg_data_mode_t;

	typedef struct packed {
		logic [1:0]       modulation_select;
		rmcfg_data_mode_t data_mode;
		logic [1:0]       ook_threshold_type;
		logic [1:0]       if_gain_select;
		logic [7:0]       deviation_value;
		logic [6:0]       bit_rate_value;
		logic [7:0]       ook_floor_value;
	} rmcfg_cfg_t;

endpackage : rmcfg_pkg

// ---- rmcfg_mode_dec.sv ----
// Decoder of the data and modulation register into its fields
`include "rmcfg_map.svh"

module rmcfg_mode_dec (
	// Raw register
	input  wire logic [7:0]                dmod,
	// Decoded fields
	output rmcfg_pkg::rmcfg_data_mode_t    data_mode,
	output logic [1:0]                     modulation_select,
	output logic [1:0]                     ook_threshold_type,
	output logic [1:0]                     if_gain_select
);
	import rmcfg_pkg::*;

	always_comb begin
		// High bit wins, low bit is then ignored
		if (dmod[`RMCFG_DMOD_MODE_HIGH]) begin
			data_mode = mode_packet;
		end else if (dmod[`RMCFG_DMOD_MODE_LOW]) begin
			data_mode = mode_buffer;
		end else begin
			data_mode = mode_continuous;
		end
		modulation_select =
			dmod[`RMCFG_DMOD_MODULATION_SELECT_HI:`RMCFG_DMOD_MODULATION_SELECT_LO];
		ook_threshold_type =
			dmod[`RMCFG_DMOD_OOKT_HI:`RMCFG_DMOD_OOKT_LO];
		if_gain_select = dmod[`RMCFG_DMOD_IFG_HI:`RMCFG_DMOD_IFG_LO];
	end

endmodule : rmcfg_mode_dec

// ---- rmcfg_rate_div.sv ----
// Tick generator with period (value + 1) shifted left by SHIFT
module rmcfg_rate_div #(
	parameter int unsigned SHIFT = 5
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Divider setting
	input  wire logic [7:0] value,
	// One-cycle pulse per period
	output logic            tick
);
	localparam int CW = 9 + SHIFT;

	logic [CW-1:0] limit;
	logic [CW-1:0] cnt;

	always_comb begin
		limit = ((CW'(value) + CW'(1)) << SHIFT) - CW'(1);
	end

	// Reload also when the setting shrinks below the running count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
		end else if (cnt == '0 || cnt > limit) begin
			cnt <= limit;
		end else begin
			cnt <= cnt - CW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 1'b0;
		end else begin
			tick <= (cnt == '0);
		end
	end

	////////////////////////////////////////////////////////////////////
	logic [CW-1:0] gap;
	logic [7:0]    value_q;
	logic          chg;
	logic          seen;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gap     <= '0;
			value_q <= 8'h00;
			chg     <= 1'b1;
			seen    <= 1'b0;
		end else begin
			gap     <= tick ? '0 : gap + CW'(1);
			value_q <= value;
			chg     <= tick ? (value != value_q)
			                : (chg || value != value_q);
			seen    <= seen || tick;
		end
	end

	property p_tick_period;
		@(posedge aclk) disable iff (!aresetn)
		tick && seen && !chg && value == value_q |-> gap == limit;
	endproperty
	a_tick_period: assert property (p_tick_period)
		else $error("tick period differs from setting");

endmodule : rmcfg_rate_div

// ---- rmcfg_regs.sv ----
// Modulation and data-rate configuration registers behind AXI4-Lite
//
// Implementation choice: the AXI4-Lite register port.
`include "rmcfg_map.svh"

module rmcfg_regs (
	// Clock and reset
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// Write address
	input  wire logic [`RMCFG_ADDR_W-1:0]   awaddr,
	input  wire logic [2:0]                 awprot,
	input  wire logic                       awvalid,
	output logic                            awready,
	// Write data
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	// Write response
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	// Read address
	input  wire logic [`RMCFG_ADDR_W-1:0]   araddr,
	input  wire logic [2:0]                 arprot,
	input  wire logic                       arvalid,
	output logic                            arready,
	// Read data
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	// Modem and synthesizer settings
	output rmcfg_pkg::rmcfg_cfg_t           cfg,
	output logic                            dev_tick,
	output logic                            bit_tick
);
	import rmcfg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Register storage, indexed 0..3 for indices 1..4

	localparam logic [7:0] RST_VAL [`RMCFG_NREG] = '{
		`RMCFG_RST_DMOD, `RMCFG_RST_FDEV,
		`RMCFG_RST_BRATE, `RMCFG_RST_FLOOR
	};
	localparam logic [7:0] WR_MASK [`RMCFG_NREG] = '{
		`RMCFG_MASK_FULL, `RMCFG_MASK_FULL,
		`RMCFG_MASK_BRATE, `RMCFG_MASK_FULL
	};
	// Power-on settings, so the modem never sees zeros during reset
	localparam rmcfg_cfg_t CFG_RST = '{
		RST_VAL[0][`RMCFG_DMOD_MODULATION_SELECT_HI:`RMCFG_DMOD_MODULATION_SELECT_LO],
		mode_continuous,
		RST_VAL[0][`RMCFG_DMOD_OOKT_HI:`RMCFG_DMOD_OOKT_LO],
		RST_VAL[0][`RMCFG_DMOD_IFG_HI:`RMCFG_DMOD_IFG_LO],
		RST_VAL[1], RST_VAL[2][6:0], RST_VAL[3]
	};

	logic [7:0]              cfg_reg [`RMCFG_NREG];
	logic                    aw_held;
	logic                    w_held;
	logic [`RMCFG_IDX_W-1:0] aw_idx_q;
	logic [7:0]              wdata_q;
	logic                    wlane_q;

	logic                    aw_take;
	logic                    w_take;
	logic                    aw_got;
	logic                    w_got;
	logic                    do_write;
	logic [`RMCFG_IDX_W-1:0] wr_idx;
	logic [7:0]              wr_data;
	logic                    wr_lane;
	logic                    wr_hit;
	logic                    next_aw_held;
	logic                    next_w_held;
	logic                    next_bvalid;

	logic [`RMCFG_IDX_W-1:0] rd_idx;
	logic                    rd_hit;
	logic [1:0]              rd_sel;
	logic [1:0]              wr_sel;

	////////////////////////////////////////////////////////////////////
	// Write channel joining; address and data may come in either order

	always_comb begin
		aw_take      = awvalid && awready;
		w_take       = wvalid && wready;
		aw_got       = aw_held || aw_take;
		w_got        = w_held || w_take;
		do_write     = aw_got && w_got;
		wr_idx       = aw_held ? aw_idx_q
		                       : awaddr[`RMCFG_ADDR_W-1:2];
		wr_data      = w_held ? wdata_q : wdata[7:0];
		wr_lane      = w_held ? wlane_q : wstrb[0];
		wr_hit       = wr_idx >= `RMCFG_IDX_DMOD
		            && wr_idx <= `RMCFG_IDX_FLOOR;
		wr_sel       = 2'(wr_idx - `RMCFG_IDX_DMOD);
		next_aw_held = aw_got && !do_write;
		next_w_held  = w_got && !do_write;
		next_bvalid  = do_write || (bvalid && !bready);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			aw_idx_q <= '0;
			wdata_q  <= 8'h00;
			wlane_q  <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			if (aw_take) begin
				aw_idx_q <= awaddr[`RMCFG_ADDR_W-1:2];
			end
			if (w_take) begin
				wdata_q <= wdata[7:0];
				wlane_q <= wstrb[0];
			end
		end
	end

	// Ready drops while a half is held or a response is pending
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= !next_aw_held && !next_bvalid;
			wready  <= !next_w_held && !next_bvalid;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RMCFG_RESP_OKAY;
		end else begin
			bvalid <= next_bvalid;
			if (do_write) begin
				bresp <= wr_hit ? `RMCFG_RESP_OKAY
				                : `RMCFG_RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Register bank; a cleared lane 0 strobe leaves the byte untouched

	for (genvar g = 0; g < `RMCFG_NREG; g++) begin : g_reg
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cfg_reg[g] <= RST_VAL[g];
			end else if (do_write && wr_lane && wr_hit
			             && wr_sel == 2'(g)) begin
				cfg_reg[g] <= wr_data & WR_MASK[g];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read channel; one cycle from address to data

	always_comb begin
		rd_idx = araddr[`RMCFG_ADDR_W-1:2];
		rd_hit = rd_idx >= `RMCFG_IDX_DMOD
		      && rd_idx <= `RMCFG_IDX_FLOOR;
		rd_sel = 2'(rd_idx - `RMCFG_IDX_DMOD);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RMCFG_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_hit ? {24'h00_0000, cfg_reg[rd_sel]}
			                  : 32'h0000_0000;
			rresp   <= rd_hit ? `RMCFG_RESP_OKAY
			                  : `RMCFG_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Settings to the modem, registered so every output is a flop

	rmcfg_data_mode_t dec_mode;
	logic [1:0]       dec_modulation_select;
	logic [1:0]       dec_ookt;
	logic [1:0]       dec_ifg;

	rmcfg_mode_dec u_dec (
		.dmod               (cfg_reg[0]),
		.data_mode          (dec_mode),
		.modulation_select  (dec_modulation_select),
		.ook_threshold_type (dec_ookt),
		.if_gain_select     (dec_ifg)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= CFG_RST;
		end else begin
			cfg.data_mode          <= dec_mode;
			cfg.modulation_select  <= dec_modulation_select;
			cfg.ook_threshold_type <= dec_ookt;
			cfg.if_gain_select     <= dec_ifg;
			cfg.deviation_value    <= cfg_reg[1];
			cfg.bit_rate_value     <= cfg_reg[2][6:0];
			cfg.ook_floor_value    <= cfg_reg[3];
		end
	end

	// Clock stands in for the reference crystal; at 12.8 MHz the
	// reset setting gives 100 kHz deviation and 25 kbps
	rmcfg_rate_div #(
		.SHIFT (`RMCFG_DEV_SHIFT)
	) u_dev_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.value   (cfg.deviation_value),
		.tick    (dev_tick)
	);

	rmcfg_rate_div #(
		.SHIFT (`RMCFG_BR_SHIFT)
	) u_bit_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.value   ({1'b0, cfg.bit_rate_value}),
		.tick    (bit_tick)
	);

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_mode_decode;
		1 |=> cfg.data_mode ==
			($past(cfg_reg[0][`RMCFG_DMOD_MODE_HIGH]) ? mode_packet
			: $past(cfg_reg[0][`RMCFG_DMOD_MODE_LOW]) ? mode_buffer
			: mode_continuous);
	endproperty
	a_mode_decode: assert property (p_mode_decode)
		else $error("data mode decode wrong");

	property p_dev_store;
		do_write && wr_lane && wr_idx == `RMCFG_IDX_FDEV
		|=> cfg_reg[1] == $past(wr_data)
		##1 cfg.deviation_value == $past(wr_data, 2);
	endproperty
	a_dev_store: assert property (p_dev_store)
		else $error("deviation write not stored");

	property p_brate_store;
		do_write && wr_lane && wr_idx == `RMCFG_IDX_BRATE
		|=> cfg_reg[2][6:0] == $past(wr_data[6:0])
		##1 cfg.bit_rate_value == $past(wr_data[6:0], 2);
	endproperty
	a_brate_store: assert property (p_brate_store)
		else $error("bit-rate write not stored");

	property p_brate_resv;
		1 |-> cfg_reg[2][7] == 1'b0;
	endproperty
	a_brate_resv: assert property (p_brate_resv)
		else $error("reserved bit-rate bit set");

	property p_floor_out;
		1 |=> cfg.ook_floor_value == $past(cfg_reg[3]);
	endproperty
	a_floor_out: assert property (p_floor_out)
		else $error("floor output not following register");

	property p_static_hold;
		!(do_write && wr_lane && wr_idx == `RMCFG_IDX_DMOD)
		|=> $stable(cfg_reg[0]) ##1 $stable(cfg.if_gain_select)
		&& $stable(cfg.modulation_select)
		&& $stable(cfg.ook_threshold_type);
	endproperty
	a_static_hold: assert property (p_static_hold)
		else $error("static field changed without write");

	property p_bit_rate_reset;
		$rose(aresetn) |-> cfg == CFG_RST;
	endproperty
	a_bit_rate_reset: assert property (p_bit_rate_reset)
		else $error("settings not at power-on values after reset");

	property p_bresp_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold)
		else $error("write response dropped before taken");

	property p_read_answer;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered in one cycle");

	c_packet_mode: cover property (
		do_write && wr_idx == `RMCFG_IDX_DMOD
		&& wr_data[`RMCFG_DMOD_MODE_HIGH] ##2 cfg.data_mode == mode_packet);
	c_read_brate: cover property (
		arvalid && arready && rd_idx == `RMCFG_IDX_BRATE);
	c_unmapped: cover property (bvalid && bresp == `RMCFG_RESP_SLVERR);
	c_bit_tick: cover property (bit_tick);

endmodule : rmcfg_regs

// ---- rmcfg_regs_bench.sv ----
// Self-checking bench for the modulation configuration registers
`include "rmcfg_map.svh"

`define CHK(g, e) begin \
	compares++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module rmcfg_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import rmcfg_pkg::*;

	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	rmcfg_cfg_t  cfg;
	logic        dev_tick;
	logic        bit_tick;
	int          bad_count;
	int          compares;
	logic [7:0]  mdl [1:4];

	rmcfg_regs dut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.cfg(cfg), .dev_tick(dev_tick), .bit_tick(bit_tick)
	);

	always #2.5 aclk = ~aclk;

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic ran_out();
		bad_count++;
		$display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		stop_test();
	endtask : ran_out

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		mdl[1] = 8'h88;
		mdl[2] = 8'h03;
		mdl[3] = 8'h07;
		mdl[4] = 8'h0c;
	endtask : do_reset

	// Bready is held from the start, allowed before bvalid
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n >= 100) ran_out();
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n >= 100) ran_out();
	endtask : axi_read

	////////////////////////////////////////////////////////////////////////
	function automatic rmcfg_cfg_t exp_cfg();
		rmcfg_cfg_t c;
		c.modulation_select = mdl[1][7:6];
		if (mdl[1][2]) c.data_mode = mode_packet;
		else if (mdl[1][5]) c.data_mode = mode_buffer;
		else c.data_mode = mode_continuous;
		c.ook_threshold_type = mdl[1][4:3];
		c.if_gain_select = mdl[1][1:0];
		c.deviation_value = mdl[2];
		c.bit_rate_value = mdl[3][6:0];
		c.ook_floor_value = mdl[4];
		return c;
	endfunction : exp_cfg

	// Model updates only on mapped index with the low strobe set
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [1:0] r;
		logic       hit;
		hit = (a[7:2] >= 6'h01) && (a[7:2] <= 6'h04);
		if (a[7:2] == 6'h03) d[7] = 1'b0;
		axi_write(a, d, s, r);
		`CHK(r, hit ? `RMCFG_RESP_OKAY : `RMCFG_RESP_SLVERR);
		if (hit && s[0]) mdl[a[7:2]] = (a[7:2] == 6'h03) ? {1'b0, d[6:0]} : d[7:0];
		repeat (2) @(posedge aclk);
	endtask : wr_chk

	task automatic chk_all();
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 1; i <= 4; i++) begin
			axi_read({i[5:0], 2'h0}, d, r);
			`CHK(d, {24'h0, mdl[i]});
			`CHK(r, `RMCFG_RESP_OKAY);
		end
		`CHK(cfg, exp_cfg());
	endtask : chk_all

	// Skips the first tick, which may come early after a reload
	task automatic tick_gap(input bit which, output int p);
		int n;
		repeat (2) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!(which ? bit_tick : dev_tick) && n < 20000);
			if (n >= 20000) ran_out();
		end
		p = n;
	endtask : tick_gap

	task automatic chk_ticks();
		int p;
		tick_gap(1'b0, p);
		`CHK(p, 32 * (mdl[2] + 1));
		tick_gap(1'b1, p);
		`CHK(p, 64 * (mdl[3][6:0] + 1));
	endtask : chk_ticks

	////////////////////////////////////////////////////////////////////////
	initial begin
		int          p;
		logic [31:0] d;
		logic [1:0]  r;
		aclk = 1'b0;
		aresetn = 1'b0;
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		bad_count = 0;
		compares = 0;
		void'($urandom(32'he576));
		do_reset();
		chk_all();
		// Rates at the 12.8 MHz reference: 100 kHz and 25 kbps
		tick_gap(1'b0, p);
		`CHK(32'hc35000 / p, 32'h186a0);
		tick_gap(1'b1, p);
		`CHK(32'hc35000 / p, 32'h61a8);
		for (int m = 0; m < 4; m++) begin
			d = $urandom;
			d[5] = m[0];
			d[2] = m[1];
			wr_chk(8'h04, d, 4'h1);
			chk_all();
		end
		// Field boundaries; the reserved bit-rate bit is kept clear
		wr_chk(8'h08, 32'hff, 4'h1);
		wr_chk(8'h0c, 32'hff, 4'h1);
		chk_all();
		chk_ticks();
		wr_chk(8'h08, 32'h0, 4'h1);
		wr_chk(8'h0c, 32'h0, 4'h1);
		chk_ticks();
		for (int k = 0; k < 12; k++) begin
			wr_chk({6'h01 + 6'(k % 4), 2'h0}, $urandom, 4'h1);
			chk_all();
		end
		chk_ticks();
		// Unmapped places and a store with the byte strobe low
		wr_chk(8'h00, $urandom, 4'h1);
		wr_chk(8'h14, $urandom, 4'hf);
		wr_chk(8'h10, $urandom, 4'he);
		axi_read(8'h14, d, r);
		`CHK(d, 32'h0);
		`CHK(r, `RMCFG_RESP_SLVERR);
		chk_all();
		// Second reset after traffic
		wr_chk(8'h04, $urandom, 4'h1);
		do_reset();
		chk_all();
		stop_test();
	end

endmodule : rmcfg_regs_bench
